// [hw/fpr_map.svh]
// register map, field positions, reset values and timing counts of the fan duty ramp block
// assumes the including file supplies nothing; definitions only
`ifndef FPR_MAP_SVH
`define FPR_MAP_SVH

// ==========================================================
// register offsets
`define FPR_OFS_FLOOR_RAMP1 8'h62
`define FPR_OFS_RAMP23 8'h63
`define FPR_OFS_MIN_DUTY1 8'h64
`define FPR_OFS_MIN_DUTY2 8'h65
`define FPR_OFS_MIN_DUTY3 8'h66

// ==========================================================
// reset values
`define FPR_RST_FLOOR_RAMP1 8'h00
`define FPR_RST_RAMP23 8'h00
`define FPR_RST_MIN_DUTY 8'h80

// ==========================================================
// field positions
`define FPR_FLOOR_SEL_LSB 5
`define FPR_RESERVED_BIT 4
`define FPR_RAMP1_EN_BIT 3
`define FPR_RAMP1_CODE_LSB 0
`define FPR_RAMP2_EN_BIT 7
`define FPR_RAMP2_CODE_LSB 4
`define FPR_RAMP3_EN_BIT 3
`define FPR_RAMP3_CODE_LSB 0

// ==========================================================
// timing: clock period in ps, one millisecond in ps, step intervals in ms
`define FPR_CLK_PERIOD_PS 4000
`define FPR_MS_PS 1000000000
`define FPR_MS_CYCLES (`FPR_MS_PS / `FPR_CLK_PERIOD_PS)
`define FPR_STEP_MS_0 8'd206
`define FPR_STEP_MS_1 8'd104
`define FPR_STEP_MS_2 8'd69
`define FPR_STEP_MS_3 8'd41
`define FPR_STEP_MS_4 8'd26
`define FPR_STEP_MS_5 8'd18
`define FPR_STEP_MS_6 8'd10
`define FPR_STEP_MS_7 8'd5
`define FPR_DUTY_FULL 8'hFF

`endif

// [hw/fpr_pkg.sv]
// types shared by the fan duty ramp block
// assumes fpr_map.svh holds the numeric constants
package fpr_pkg;

	// ==========================================================
	// types
	typedef logic [7:0] fpr_duty_t;
	typedef logic [2:0] fpr_step_code_t;
	typedef logic signed [7:0] fpr_temp_t;

endpackage : fpr_pkg

// [hw/fpr_top.sv]
// fan duty target and ramp limiter for three automatic fan channels, with its control registers
// assumes a register access port driven by the serial port decoder, synchronous to ref_clk_i,
// and zone temperature, limit, hysteresis and slope supplied per channel by the zone logic
`timescale 1ns/10ps
`include "fpr_map.svh"

module fpr_top import fpr_pkg::*; #(
	parameter int unsigned MS_CYCLES = `FPR_MS_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic lock_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic [2:0] sample_valid_i,
	input wire logic [7:0] temp_ch1_i,
	input wire logic [7:0] temp_ch2_i,
	input wire logic [7:0] temp_ch3_i,
	input wire logic [7:0] low_limit_ch1_i,
	input wire logic [7:0] low_limit_ch2_i,
	input wire logic [7:0] low_limit_ch3_i,
	input wire logic [3:0] hyst_ch1_i,
	input wire logic [3:0] hyst_ch2_i,
	input wire logic [3:0] hyst_ch3_i,
	input wire logic [7:0] slope_ch1_i,
	input wire logic [7:0] slope_ch2_i,
	input wire logic [7:0] slope_ch3_i,
	output logic [7:0] duty_ch1_o,
	output logic [7:0] duty_ch2_o,
	output logic [7:0] duty_ch3_o,
	output logic [2:0] fan_on_o
);

	// ==========================================================
	// helpers
	function automatic logic [7:0] step_ms(input fpr_step_code_t code);
		logic [7:0] ms;
		ms = `FPR_STEP_MS_0;
		case (code)
			3'h0: ms = `FPR_STEP_MS_0;
			3'h1: ms = `FPR_STEP_MS_1;
			3'h2: ms = `FPR_STEP_MS_2;
			3'h3: ms = `FPR_STEP_MS_3;
			3'h4: ms = `FPR_STEP_MS_4;
			3'h5: ms = `FPR_STEP_MS_5;
			3'h6: ms = `FPR_STEP_MS_6;
			default: ms = `FPR_STEP_MS_7;
		endcase
		return ms;
	endfunction : step_ms

	// ==========================================================
	// control registers
	logic [7:0] floor_ramp1_r;
	logic [7:0] ramp23_r;
	fpr_duty_t min_duty_r [3];
	logic [7:0] reg_rdata_r;
	logic reg_rvalid_r;

	wire wr_ok = reg_wr_i & ~lock_i;
	wire hit_fr1 = (reg_addr_i == `FPR_OFS_FLOOR_RAMP1);
	wire hit_r23 = (reg_addr_i == `FPR_OFS_RAMP23);
	wire hit_min1 = (reg_addr_i == `FPR_OFS_MIN_DUTY1);
	wire hit_min2 = (reg_addr_i == `FPR_OFS_MIN_DUTY2);
	wire hit_min3 = (reg_addr_i == `FPR_OFS_MIN_DUTY3);
	wire [2:0] hit_min = {hit_min3, hit_min2, hit_min1};

	// the reserved bit is never stored so it always reads back as zero
	logic [7:0] fr1_wmask;
	assign fr1_wmask = ~(8'h01 << `FPR_RESERVED_BIT);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			floor_ramp1_r <= `FPR_RST_FLOOR_RAMP1;
		end else if (wr_ok && hit_fr1) begin
			floor_ramp1_r <= reg_wdata_i & fr1_wmask;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ramp23_r <= `FPR_RST_RAMP23;
		end else if (wr_ok && hit_r23) begin
			ramp23_r <= reg_wdata_i;
		end
	end

	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (hit_fr1) begin
			rd_mux = floor_ramp1_r;
		end else if (hit_r23) begin
			rd_mux = ramp23_r;
		end else if (hit_min1) begin
			rd_mux = min_duty_r[0];
		end else if (hit_min2) begin
			rd_mux = min_duty_r[1];
		end else if (hit_min3) begin
			rd_mux = min_duty_r[2];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			reg_rdata_r <= 8'h00;
			reg_rvalid_r <= 1'b0;
		end else begin
			reg_rvalid_r <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_r <= rd_mux;
			end
		end
	end

	assign reg_rdata_o = reg_rdata_r;
	assign reg_rvalid_o = reg_rvalid_r;

	// ==========================================================
	// per-channel field decode
	wire [2:0] floor_sel = floor_ramp1_r[`FPR_FLOOR_SEL_LSB +: 3];
	wire [2:0] ramp_en = {ramp23_r[`FPR_RAMP3_EN_BIT], ramp23_r[`FPR_RAMP2_EN_BIT],
		floor_ramp1_r[`FPR_RAMP1_EN_BIT]};
	fpr_step_code_t ramp_code [3];
	assign ramp_code[0] = floor_ramp1_r[`FPR_RAMP1_CODE_LSB +: 3];
	assign ramp_code[1] = ramp23_r[`FPR_RAMP2_CODE_LSB +: 3];
	assign ramp_code[2] = ramp23_r[`FPR_RAMP3_CODE_LSB +: 3];

	fpr_temp_t temp [3];
	fpr_temp_t low_limit [3];
	logic [3:0] hyst [3];
	logic [7:0] slope [3];
	assign temp[0] = temp_ch1_i;
	assign temp[1] = temp_ch2_i;
	assign temp[2] = temp_ch3_i;
	assign low_limit[0] = low_limit_ch1_i;
	assign low_limit[1] = low_limit_ch2_i;
	assign low_limit[2] = low_limit_ch3_i;
	assign hyst[0] = hyst_ch1_i;
	assign hyst[1] = hyst_ch2_i;
	assign hyst[2] = hyst_ch3_i;
	assign slope[0] = slope_ch1_i;
	assign slope[1] = slope_ch2_i;
	assign slope[2] = slope_ch3_i;

	// ==========================================================
	// shared millisecond tick; long count so it is a parameter for short simulations
	logic [31:0] ms_cnt_r;
	logic ms_tick_r;
	wire ms_wrap = (ms_cnt_r == 32'(MS_CYCLES - 1));

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ms_cnt_r <= 32'h0000_0000;
			ms_tick_r <= 1'b0;
		end else begin
			ms_cnt_r <= ms_wrap ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
			ms_tick_r <= ms_wrap;
		end
	end

	// ==========================================================
	// channels
	fpr_duty_t duty_r [3];
	logic [2:0] fan_on_r;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ch
			fpr_duty_t target_r;
			logic [7:0] step_cnt_r;
			logic step_tick;

			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					min_duty_r[g] <= `FPR_RST_MIN_DUTY;
				end else if (wr_ok && hit_min[g]) begin
					min_duty_r[g] <= reg_wdata_i;
				end
			end

			// signed distances, nine bits so no wrap at the ends of the range
			wire signed [8:0] over = 9'(temp[g]) - 9'(low_limit[g]);
			wire signed [8:0] off_pt = 9'(low_limit[g]) - $signed({5'h00, hyst[g]});
			wire at_or_above = (over >= 9'sd0);
			wire below_hyst = ($signed(9'(temp[g])) < off_pt);
			wire [15:0] rise = slope[g] * over[7:0];
			wire [16:0] lin = 17'(min_duty_r[g]) + 17'(rise);
			wire fpr_duty_t lin_sat = (lin > 17'(`FPR_DUTY_FULL)) ? `FPR_DUTY_FULL : lin[7:0];

			// hysteresis decides whether a zero-floor channel is still running
			logic fan_on_nxt;
			always_comb begin
				fan_on_nxt = fan_on_r[g];
				if (at_or_above) begin
					fan_on_nxt = 1'b1;
				end else if (below_hyst) begin
					fan_on_nxt = 1'b0;
				end
			end

			logic [7:0] target_nxt;
			always_comb begin
				if (at_or_above) begin
					target_nxt = lin_sat;
				end else if (floor_sel[g] || fan_on_nxt) begin
					target_nxt = min_duty_r[g];
				end else begin
					target_nxt = 8'h00;
				end
			end

			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					fan_on_r[g] <= 1'b0;
					target_r <= 8'h00;
				end else if (sample_valid_i[g]) begin
					fan_on_r[g] <= fan_on_nxt;
					target_r <= target_nxt;
				end
			end

			// step interval counter, held cleared while ramping is off
			wire [7:0] last_ms = step_ms(ramp_code[g]) - 8'h01;
			assign step_tick = ms_tick_r && (step_cnt_r >= last_ms);

			always_ff @(posedge ref_clk_i) begin
				if (rst_i || !ramp_en[g]) begin
					step_cnt_r <= 8'h00;
				end else if (ms_tick_r) begin
					step_cnt_r <= step_tick ? 8'h00 : step_cnt_r + 8'h01;
				end
			end

			logic [7:0] duty_nxt;
			always_comb begin
				duty_nxt = duty_r[g];
				if (!ramp_en[g]) begin
					duty_nxt = target_r;
				end else if (step_tick && duty_r[g] < target_r) begin
					duty_nxt = duty_r[g] + 8'h01;
				end else if (step_tick && duty_r[g] > target_r) begin
					duty_nxt = duty_r[g] - 8'h01;
				end
			end

			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					duty_r[g] <= 8'h00;
				end else begin
					duty_r[g] <= duty_nxt;
				end
			end
		end
	endgenerate

	assign duty_ch1_o = duty_r[0];
	assign duty_ch2_o = duty_r[1];
	assign duty_ch3_o = duty_r[2];
	assign fan_on_o = fan_on_r;

endmodule : fpr_top

// [tb/fpr_fan_model.sv]
// fan model: rotor speed creeps toward the applied duty
// assumes one clock and the duty output of one channel
`timescale 1ns/10ps
module fpr_fan_model (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] duty_i,
	output logic [7:0] speed_o
);
	// ==========
	// rotor
	// inertia: a real rotor never follows a duty jump at once
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			speed_o <= 8'h00;
		end else if (speed_o != duty_i) begin
			speed_o <= (speed_o < duty_i) ? speed_o + 8'h01 : speed_o - 8'h01;
		end
	end
endmodule : fpr_fan_model

// [tb/fpr_top_bench.sv]
// self-checking bench for fpr_top: registers, floor select, linear duty, ramp limiter
// assumes MS_CYCLES of 4, so one millisecond lasts four clocks
`timescale 1ns/10ps
module fpr_top_bench;
	localparam int MS = 4;
	localparam int STEP_MS[8] = '{206, 104, 69, 41, 26, 18, 10, 5};
	logic ref_clk_i = 1'b0, rst_i = 1'b1, lock_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, tp = 8'h00, lim = 8'h32, sl = 8'h04;
	logic [7:0] p;
	logic [3:0] hy = 4'h2;
	logic [2:0] sample_valid_i = 3'h0;
	wire logic [7:0] reg_rdata_o, duty_ch1_o, duty_ch2_o, duty_ch3_o;
	wire logic [7:0] duty [3];
	wire logic reg_rvalid_o;
	wire logic [2:0] fan_on_o;
	int errors = 0, comparisons = 0, cyc = 0, n;
	assign duty[0] = duty_ch1_o;
	assign duty[1] = duty_ch2_o;
	assign duty[2] = duty_ch3_o;
	fpr_top #(.MS_CYCLES(MS)) uut (
		.ref_clk_i, .rst_i, .lock_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .reg_rvalid_o, .sample_valid_i, .temp_ch1_i(tp), .temp_ch2_i(tp),
		.temp_ch3_i(tp), .low_limit_ch1_i(lim), .low_limit_ch2_i(lim), .low_limit_ch3_i(lim),
		.hyst_ch1_i(hy), .hyst_ch2_i(hy), .hyst_ch3_i(hy), .slope_ch1_i(sl), .slope_ch2_i(sl),
		.slope_ch3_i(sl), .duty_ch1_o, .duty_ch2_o, .duty_ch3_o, .fan_on_o
	);
	fpr_fan_model fan1 (.ref_clk_i, .rst_i, .duty_i(duty_ch1_o), .speed_o());
	fpr_fan_model fan2 (.ref_clk_i, .rst_i, .duty_i(duty_ch2_o), .speed_o());
	fpr_fan_model fan3 (.ref_clk_i, .rst_i, .duty_i(duty_ch3_o), .speed_o());
	initial forever #2 ref_clk_i = ~ref_clk_i;
	// ==========
	// tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		// rvalid stands for one cycle only, so look just after the edge that raises it
		#1;
		chk({7'h00, reg_rvalid_o, reg_rdata_o}, {8'h01, e});
	endtask : rd
	task automatic samp(input logic [7:0] t);
		@(posedge ref_clk_i);
		tp <= t;
		sample_valid_i <= 3'h7;
		@(posedge ref_clk_i);
		sample_valid_i <= 3'h0;
		@(posedge ref_clk_i);
		#1;
	endtask : samp
	task automatic dchk(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
		chk({duty_ch1_o, duty_ch2_o}, {e1, e2});
		chk({8'h00, duty_ch3_o}, {8'h00, e3});
	endtask : dchk
	// counts clocks until the channel's duty moves; p keeps the value before the move
	task automatic gap(input int ch);
		p = duty[ch];
		n = 0;
		while (duty[ch] === p && n < 900) begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
	endtask : gap
	task automatic close_out();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			errors++;
			close_out();
		end
	end
	// ==========
	// sequence
	initial begin
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(8'(8'h62 + i), (i < 2) ? 8'h00 : 8'h80);
		end
		rd(8'h70, 8'h00);
		wr(8'h62, 8'hFF);
		rd(8'h62, 8'hEF);
		wr(8'h64, 8'h40);
		wr(8'h66, 8'hFF);
		rd(8'h66, 8'hFF);
		@(posedge ref_clk_i);
		lock_i <= 1'b1;
		wr(8'h64, 8'h11);
		wr(8'h62, 8'h00);
		rd(8'h64, 8'h40);
		rd(8'h62, 8'hEF);
		@(posedge ref_clk_i);
		lock_i <= 1'b0;
		wr(8'h62, 8'h40);
		samp(8'h32);
		dchk(8'h40, 8'h80, 8'hFF);
		samp(8'h35);
		dchk(8'h4C, 8'h8C, 8'hFF);
		samp(8'h31);
		dchk(8'h40, 8'h80, 8'hFF);
		samp(8'h2D);
		dchk(8'h00, 8'h80, 8'h00);
		chk({13'h0000, fan_on_o}, 16'h0000);
		wr(8'h62, 8'h4F);
		samp(8'h50);
		dchk(8'h00, 8'hF8, 8'hFF);
		gap(0);
		chk({8'h00, duty_ch1_o}, 16'h0001);
		// slowest code last: a shorter limit never lands below a running count
		for (int c = 7; c >= 0; c--) begin
			wr(8'h62, 8'h48 | 8'(c));
			gap(0);
			gap(0);
			chk(16'(n), 16'(STEP_MS[c] * MS));
		end
		wr(8'h63, 8'hFE);
		rd(8'h63, 8'hFE);
		wr(8'h62, 8'h4F);
		samp(8'h28);
		// channels 2 and 3 run different codes so swapped fields would show
		gap(1);
		gap(1);
		chk(16'(n), 16'(STEP_MS[7] * MS));
		chk({8'h00, duty_ch2_o}, {8'h00, p - 8'h01});
		gap(2);
		gap(2);
		chk(16'(n), 16'(STEP_MS[6] * MS));
		gap(0);
		chk({8'h00, duty_ch1_o}, {8'h00, p - 8'h01});
		close_out();
	end
endmodule : fpr_top_bench

// [tb/fpr_top_properties.sv]
// assertions on the register port and duty outputs of fpr_top
// assumes a bind to fpr_top; shadows the two ramp control registers
`timescale 1ns/10ps
module fpr_chk #(
	parameter int unsigned MS_CYCLES = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic lock_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic [7:0] duty_ch1_o,
	input wire logic [7:0] duty_ch2_o,
	input wire logic [7:0] duty_ch3_o
);
	// ==========
	// shadow registers
	logic [7:0] r62_r, r63_r;
	logic [2:0] en1_r, en2_r;
	wire logic wr_ok = reg_wr_i && !lock_i;
	wire logic hit62 = wr_ok && reg_addr_i == 8'h62;
	wire logic hit63 = wr_ok && reg_addr_i == 8'h63;
	wire logic [2:0] en = {r63_r[3], r63_r[7], r62_r[3]};
	// enable must have stood three cycles, else a jump launched before it is legal
	wire logic [2:0] held = en & en1_r & en2_r;
	always_ff @(posedge ref_clk_i) begin
		r62_r <= rst_i ? 8'h00 : hit62 ? (reg_wdata_i & 8'hEF) : r62_r;
		r63_r <= rst_i ? 8'h00 : hit63 ? reg_wdata_i : r63_r;
		en1_r <= rst_i ? 3'h0 : en;
		en2_r <= rst_i ? 3'h0 : en1_r;
	end
	// ==========
	// properties
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	property p_rd62;
		reg_rd_i && reg_addr_i == 8'h62 |=> reg_rvalid_o && reg_rdata_o == $past(r62_r);
	endproperty
	a_rd62: assert property (p_rd62) else $error("bad read of 62");
	property p_rd63;
		reg_rd_i && reg_addr_i == 8'h63 |=> reg_rvalid_o && reg_rdata_o == $past(r63_r);
	endproperty
	a_rd63: assert property (p_rd63) else $error("bad read of 63");
	property p_step1;
		held[0] |-> duty_ch1_o - $past(duty_ch1_o) + 8'h01 <= 8'h02;
	endproperty
	a_step1: assert property (p_step1) else $error("ch1 ramp jump");
	property p_step2;
		held[1] |-> $past(duty_ch2_o) - duty_ch2_o + 8'h01 <= 8'h02;
	endproperty
	a_step2: assert property (p_step2) else $error("ch2 ramp jump");
	property p_step3;
		held[2] && $changed(duty_ch3_o) |->
			duty_ch3_o == $past(duty_ch3_o) + 8'h01 || duty_ch3_o == $past(duty_ch3_o) - 8'h01;
	endproperty
	a_step3: assert property (p_step3) else $error("ch3 ramp jump");
	property p_gap1;
		MS_CYCLES > 0 && held[0] && $changed(duty_ch1_o) |=> $stable(duty_ch1_o);
	endproperty
	a_gap1: assert property (p_gap1) else $error("ch1 steps too fast");
	property p_gap2;
		held[1] && $changed(duty_ch2_o) |=> $stable(duty_ch2_o) [*4];
	endproperty
	a_gap2: assert property (p_gap2) else $error("ch2 steps too fast");
	property p_gap3;
		held[2] && $changed(duty_ch3_o) |=> ##3 $stable(duty_ch3_o);
	endproperty
	a_gap3: assert property (p_gap3) else $error("ch3 steps too fast");
endmodule : fpr_chk
bind fpr_top fpr_chk #(.MS_CYCLES(MS_CYCLES)) chk_u (
	.ref_clk_i, .rst_i, .lock_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
	.reg_rdata_o, .reg_rvalid_o, .duty_ch1_o, .duty_ch2_o, .duty_ch3_o
);
